// [hw/mise_pkg.sv]
// Shared constants for the instruction subset executor: register map,
// status bit positions, reset values and instruction encodings.
// Assumes a 14-bit instruction word and an 8-bit data path.
package mise_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int INSTR_W = 14;
  localparam int AXI_AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_STACK = 8'h10;
  localparam logic [7:0] OFF_FADDR = 8'h14;
  localparam logic [7:0] OFF_FDATA = 8'h18;
  // Status register bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_IRQ_EN = 3;
  localparam int ST_SKIP = 4;
  localparam int ST_BUSY = 5;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;
  // Instruction encodings, matched against the top bits of the word
  localparam logic [4:0] OPC_ADD_LIT = 5'h1F;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
  localparam logic [3:0] OPC_RET_LIT = 4'hD;
  localparam logic [5:0] OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [6:0] OPC_STORE_ACC = 7'h01;
  localparam logic [3:0] OPC_BIT_CLR = 4'h4;
  localparam logic [3:0] OPC_BIT_SET = 4'h5;
  localparam logic [3:0] OPC_SKIP_ZERO = 4'h6;
  localparam logic [3:0] OPC_SKIP_ONE = 4'h7;
  localparam logic [13:0] OPC_RET_IRQ = 14'h0009;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MISE_ALU_ADD, MISE_ALU_AND, MISE_ALU_PASS} mise_alu_op_t;
  typedef enum logic {MISE_RUN, MISE_RET_WAIT} mise_state_t;
endpackage

// [hw/mise_core_if.sv]
// Carrier between the executor and its arithmetic unit and data file.
// Assumes one core driver; the unit and the file only answer.
`timescale 1ns/1ns
interface mise_core_if;
  logic [mise_pkg::DATA_W-1:0] alu_a;
  logic [mise_pkg::DATA_W-1:0] alu_b;
  logic [mise_pkg::DATA_W-1:0] alu_res;
  mise_pkg::mise_alu_op_t alu_op;
  logic alu_c;
  logic alu_hc;
  logic alu_z;
  logic [mise_pkg::FADDR_W-1:0] rd_addr_a;
  logic [mise_pkg::FADDR_W-1:0] rd_addr_b;
  logic [mise_pkg::FADDR_W-1:0] wr_addr;
  logic [mise_pkg::DATA_W-1:0] rd_data_a;
  logic [mise_pkg::DATA_W-1:0] rd_data_b;
  logic [mise_pkg::DATA_W-1:0] wr_data;
  logic wr_en;
  modport core (output alu_a, alu_b, alu_op, rd_addr_a, rd_addr_b, wr_addr, wr_data, wr_en,
                input alu_res, alu_c, alu_hc, alu_z, rd_data_a, rd_data_b);
  modport alu (input alu_a, alu_b, alu_op, output alu_res, alu_c, alu_hc, alu_z);
  modport rf (input rd_addr_a, rd_addr_b, wr_addr, wr_data, wr_en, output rd_data_a, rd_data_b);
endinterface

// [hw/mise_alu.sv]
// Combinational arithmetic unit: add, and, pass, with carry flags.
// Assumes operands are stable for the whole cycle.
`timescale 1ns/1ns
module mise_alu (
  mise_core_if.alu bus
);
  logic [mise_pkg::DATA_W:0] sum;
  logic [4:0] low_sum;
  // Nine-bit sum keeps carry out of bit 7, five-bit sum that of bit 3
  assign sum = {1'b0, bus.alu_a} + {1'b0, bus.alu_b};
  assign low_sum = {1'b0, bus.alu_a[3:0]} + {1'b0, bus.alu_b[3:0]};
  assign bus.alu_c = sum[mise_pkg::DATA_W];
  assign bus.alu_hc = low_sum[4];
  // Result selection by operation
  assign bus.alu_res = (bus.alu_op == mise_pkg::MISE_ALU_ADD) ? sum[mise_pkg::DATA_W-1:0] :
                       (bus.alu_op == mise_pkg::MISE_ALU_AND) ? (bus.alu_a & bus.alu_b) :
                       bus.alu_b;
  assign bus.alu_z = (bus.alu_res == 8'h00);
endmodule // mise_alu

// [hw/mise_regfile.sv]
// Data register file in flip-flops: two read ports, one write port.
// Assumes the core never asks for two writes in one cycle.
`timescale 1ns/1ns
module mise_regfile #(
  parameter int DEPTH = 2 ** mise_pkg::FADDR_W
) (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  mise_core_if.rf bus
);
  logic [mise_pkg::DATA_W-1:0] mem [DEPTH];
  // One small register per entry, cleared by reset, frozen by ce
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mem[i] <= 8'h00;
      end else if (ce && bus.wr_en && bus.wr_addr == mise_pkg::FADDR_W'(i)) begin
        mem[i] <= bus.wr_data;
      end
    end
  end
  // Reads are combinational, indexed straight from the address
  assign bus.rd_data_a = mem[bus.rd_addr_a];
  assign bus.rd_data_b = mem[bus.rd_addr_b];
endmodule // mise_regfile

// [hw/mise_exec.sv]
// Instruction subset executor with an AXI4-Lite register port.
// Assumes one clock, synchronous active-low reset, and a master that
// offers write address and data together.
`timescale 1ns/1ns
module mise_exec (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic [mise_pkg::AXI_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [mise_pkg::AXI_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [mise_pkg::PC_W-1:0] pc,
  output logic global_irq_enable
);
  mise_core_if cif ();
  mise_pkg::mise_state_t state;
  logic [mise_pkg::DATA_W-1:0] acc;
  logic [mise_pkg::INSTR_W-1:0] instr;
  logic [mise_pkg::PC_W-1:0] stack_top_entry;
  logic [mise_pkg::FADDR_W-1:0] file_addr;
  logic carry;
  logic half_carry_flag;
  logic zero;
  logic skip_pending;
  logic busy;

  mise_alu mise_alu_inst (
    .bus(cif.alu)
  );

  mise_regfile mise_regfile_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .bus(cif.rf)
  );

  // Write channel: address and data are taken together; stalled while
  // a return finishes so no instruction lands in its second cycle
  logic wr_go;
  logic rd_go;
  logic [7:0] wa;
  logic lanes_lo;
  logic lanes_16;
  assign wr_go = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !busy;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = ce && s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign wa = s_axi_awaddr;
  assign lanes_lo = s_axi_wstrb[0];
  assign lanes_16 = &s_axi_wstrb[1:0];

  // Write address decode
  logic sw_instr;
  logic sw_acc;
  logic sw_status;
  logic sw_pc;
  logic sw_stack;
  logic sw_faddr;
  logic sw_file;
  logic wr_hit;
  assign sw_instr = wr_go && wa == mise_pkg::OFF_INSTR && lanes_16;
  assign sw_acc = wr_go && wa == mise_pkg::OFF_ACC && lanes_lo;
  assign sw_status = wr_go && wa == mise_pkg::OFF_STATUS && lanes_lo;
  assign sw_pc = wr_go && wa == mise_pkg::OFF_PC && lanes_16;
  assign sw_stack = wr_go && wa == mise_pkg::OFF_STACK && lanes_16;
  assign sw_faddr = wr_go && wa == mise_pkg::OFF_FADDR && lanes_lo;
  assign sw_file = wr_go && wa == mise_pkg::OFF_FDATA && lanes_lo;
  assign wr_hit = wa == mise_pkg::OFF_INSTR || wa == mise_pkg::OFF_ACC ||
                  wa == mise_pkg::OFF_STATUS || wa == mise_pkg::OFF_PC ||
                  wa == mise_pkg::OFF_STACK || wa == mise_pkg::OFF_FADDR ||
                  wa == mise_pkg::OFF_FDATA;

  // Issue: a word written to the instruction register runs at once,
  // unless a taken skip is pending, in which case it is thrown away
  logic [mise_pkg::INSTR_W-1:0] iw;
  logic exec;
  logic discard;
  assign iw = s_axi_wdata[mise_pkg::INSTR_W-1:0];
  assign exec = sw_instr && !skip_pending;
  assign discard = sw_instr && skip_pending;

  // Instruction decode
  logic add_lit, and_lit, load_lit, ret_lit, add_f, and_f, move_f;
  logic store_f, bclr, bset, skip_z, skip_o, ret_irq;
  assign add_lit = iw[13:9] == mise_pkg::OPC_ADD_LIT;
  assign and_lit = iw[13:8] == mise_pkg::OPC_AND_LIT;
  assign load_lit = iw[13:10] == mise_pkg::OPC_LOAD_LIT;
  assign ret_lit = iw[13:10] == mise_pkg::OPC_RET_LIT;
  assign add_f = iw[13:8] == mise_pkg::OPC_ADD_FILE;
  assign and_f = iw[13:8] == mise_pkg::OPC_AND_FILE;
  assign move_f = iw[13:8] == mise_pkg::OPC_MOVE_FILE;
  assign store_f = iw[13:7] == mise_pkg::OPC_STORE_ACC;
  assign bclr = iw[13:10] == mise_pkg::OPC_BIT_CLR;
  assign bset = iw[13:10] == mise_pkg::OPC_BIT_SET;
  assign skip_z = iw[13:10] == mise_pkg::OPC_SKIP_ZERO;
  assign skip_o = iw[13:10] == mise_pkg::OPC_SKIP_ONE;
  assign ret_irq = iw == mise_pkg::OPC_RET_IRQ;
  // Any other word, the no-operation among them, falls through untouched

  // Operand fields
  logic [7:0] lit;
  logic [6:0] faddr;
  logic [2:0] bpos;
  logic dsel;
  logic [7:0] bmask;
  logic tbit;
  assign lit = iw[7:0];
  assign faddr = iw[6:0];
  assign bpos = iw[9:7];
  assign dsel = iw[7];
  assign bmask = 8'h01 << bpos;
  assign tbit = cif.rd_data_a[bpos];

  // Operation classes
  logic is_add;
  logic is_and;
  logic file_alu;
  logic is_ret;
  logic skip_now;
  assign is_add = add_lit || add_f;
  assign is_and = and_lit || and_f;
  assign file_alu = add_f || and_f || move_f;
  assign is_ret = ret_lit || ret_irq;
  assign skip_now = exec && ((skip_o && tbit) || (skip_z && !tbit));

  // Arithmetic unit hookup: literal forms take k, file forms the register
  assign cif.alu_a = acc;
  assign cif.alu_b = (add_lit || and_lit) ? lit : cif.rd_data_a;
  assign cif.alu_op = is_add ? mise_pkg::MISE_ALU_ADD :
                      is_and ? mise_pkg::MISE_ALU_AND : mise_pkg::MISE_ALU_PASS;
  assign cif.rd_addr_a = faddr;
  assign cif.rd_addr_b = file_addr;

  // Accumulator destination selection
  logic acc_ld;
  logic [7:0] acc_val;
  logic [7:0] next_acc;
  assign acc_ld = exec && (add_lit || and_lit || load_lit || ret_lit ||
                           (file_alu && !dsel));
  assign acc_val = (load_lit || ret_lit) ? lit : cif.alu_res;
  assign next_acc = sw_acc ? s_axi_wdata[7:0] : acc_ld ? acc_val : acc;

  // File write port: software window wins, else the instruction result
  logic f_we;
  assign f_we = exec && ((file_alu && dsel) || store_f || bclr || bset);
  assign cif.wr_en = sw_file || f_we;
  assign cif.wr_addr = sw_file ? file_addr : faddr;
  assign cif.wr_data = sw_file ? s_axi_wdata[7:0] :
                       store_f ? acc :
                       bclr ? (cif.rd_data_a & ~bmask) :
                       bset ? (cif.rd_data_a | bmask) :
                       cif.alu_res;

  // Flags: only add, and, move touch them; bit ops, loads, stores,
  // skips and returns leave them alone
  logic flag_cz;
  logic flag_z;
  logic next_carry;
  logic next_half;
  logic next_zero;
  assign flag_cz = exec && is_add;
  assign flag_z = exec && (is_add || is_and || move_f);
  assign next_carry = sw_status ? s_axi_wdata[mise_pkg::ST_CARRY] :
                      flag_cz ? cif.alu_c : carry;
  assign next_half = sw_status ? s_axi_wdata[mise_pkg::ST_HALF] :
                     flag_cz ? cif.alu_hc : half_carry_flag;
  assign next_zero = sw_status ? s_axi_wdata[mise_pkg::ST_ZERO] :
                     flag_z ? cif.alu_z : zero;

  // Irq enable: a return from interrupt sets it, software may write it
  logic next_global_irq_enable;
  assign next_global_irq_enable = sw_status ? s_axi_wdata[mise_pkg::ST_IRQ_EN] :
                                  (exec && ret_irq) ? 1'b1 : global_irq_enable;

  // Program counter: returns reload from the stack top, every other
  // issued word, discarded ones too, advances it by one
  logic [mise_pkg::PC_W-1:0] next_pc;
  assign next_pc = sw_pc ? s_axi_wdata[mise_pkg::PC_W-1:0] :
                   (exec && is_ret) ? stack_top_entry :
                   sw_instr ? pc + 13'h0001 : pc;

  // Skip marker: set by a taken test, cleared when the victim arrives
  logic next_skip;
  assign next_skip = skip_now ? 1'b1 : discard ? 1'b0 : skip_pending;

  // Return sequencing: the second cycle of a return blocks new words
  mise_pkg::mise_state_t next_state;
  always_comb begin
    case (state)
      mise_pkg::MISE_RUN: begin
        next_state = (exec && is_ret) ? mise_pkg::MISE_RET_WAIT : mise_pkg::MISE_RUN;
      end
      mise_pkg::MISE_RET_WAIT: begin
        next_state = mise_pkg::MISE_RUN;
      end
      default: begin
        next_state = mise_pkg::MISE_RUN;
      end
    endcase
  end
  assign busy = state == mise_pkg::MISE_RET_WAIT;

  // Core state registers, all frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= mise_pkg::MISE_RUN;
      acc <= mise_pkg::ACC_RST;
      pc <= mise_pkg::PC_RST;
      carry <= 1'b0;
      half_carry_flag <= 1'b0;
      zero <= 1'b0;
      global_irq_enable <= 1'b0;
      skip_pending <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      acc <= next_acc;
      pc <= next_pc;
      carry <= next_carry;
      half_carry_flag <= next_half;
      zero <= next_zero;
      global_irq_enable <= next_global_irq_enable;
      skip_pending <= next_skip;
    end
  end

  // Software-only registers: last issued word, stack top, file pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr <= mise_pkg::INSTR_RST;
      stack_top_entry <= mise_pkg::PC_RST;
      file_addr <= 7'h00;
    end else if (ce) begin
      if (sw_instr) instr <= iw;
      if (sw_stack) stack_top_entry <= s_axi_wdata[mise_pkg::PC_W-1:0];
      if (sw_faddr) file_addr <= s_axi_wdata[mise_pkg::FADDR_W-1:0];
    end
  end

  // Read data selection; unmapped addresses read zero with an error
  logic [31:0] rd_mux;
  logic [7:0] status_rd;
  logic rd_hit;
  assign status_rd = {2'b00, busy, skip_pending, global_irq_enable, zero, half_carry_flag, carry};
  assign rd_mux = (s_axi_araddr == mise_pkg::OFF_INSTR) ? {18'h00000, instr} :
                  (s_axi_araddr == mise_pkg::OFF_ACC) ? {24'h000000, acc} :
                  (s_axi_araddr == mise_pkg::OFF_STATUS) ? {24'h000000, status_rd} :
                  (s_axi_araddr == mise_pkg::OFF_PC) ? {19'h00000, pc} :
                  (s_axi_araddr == mise_pkg::OFF_STACK) ? {19'h00000, stack_top_entry} :
                  (s_axi_araddr == mise_pkg::OFF_FADDR) ? {25'h0000000, file_addr} :
                  (s_axi_araddr == mise_pkg::OFF_FDATA) ? {24'h000000, cif.rd_data_b} :
                  32'h00000000;
  assign rd_hit = s_axi_araddr == mise_pkg::OFF_INSTR || s_axi_araddr == mise_pkg::OFF_ACC ||
                  s_axi_araddr == mise_pkg::OFF_STATUS || s_axi_araddr == mise_pkg::OFF_PC ||
                  s_axi_araddr == mise_pkg::OFF_STACK || s_axi_araddr == mise_pkg::OFF_FADDR ||
                  s_axi_araddr == mise_pkg::OFF_FDATA;

  // Write response: one cycle after the handshake, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mise_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? mise_pkg::RESP_OKAY : mise_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read response: data captured at the handshake, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= mise_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? mise_pkg::RESP_OKAY : mise_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks on the executed behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_skip_taken;
    skip_now;
  endsequence
  sequence s_ret_issue;
    exec && is_ret;
  endsequence
  sequence s_ret_done;
    busy ##1 (!busy || !ce);
  endsequence

  add_literal_sum_a: assert property (exec && add_lit |=>
    {carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(lit)})
    else $error("add literal result wrong");
  dest_file_keep_a: assert property (exec && add_f && dsel && !sw_acc |=>
    acc == $past(acc))
    else $error("file destination changed accumulator");
  bit_ops_flags_a: assert property (exec && (bclr || bset) |=>
    $stable({carry, half_carry_flag, zero}))
    else $error("bit operation changed a flag");
  bit_set_data_a: assert property (exec && bset |-> cif.wr_en && cif.wr_data[iw[9:7]] &&
    ((cif.wr_data ^ cif.rd_data_a) | (8'h01 << iw[9:7])) == (8'h01 << iw[9:7]) &&
    cif.wr_addr == iw[6:0])
    else $error("bit set wrote wrong value");
  and_literal_zero_a: assert property (exec && and_lit |=>
    acc == ($past(acc) & $past(lit)) && zero == (acc == 8'h00) && carry == $past(carry))
    else $error("and literal result or flags wrong");
  skip_discard_a: assert property (s_skip_taken |=> skip_pending)
    else $error("taken skip not recorded");
  victim_dropped_a: assert property (discard |=>
    acc == $past(acc) && !skip_pending && $stable({carry, zero}))
    else $error("discarded word had an effect");
  load_literal_a: assert property (exec && load_lit |=>
    acc == $past(lit) && $stable({carry, half_carry_flag, zero}))
    else $error("load literal wrong");
  irq_return_a: assert property (exec && ret_irq |=>
    global_irq_enable && pc == $past(stack_top_entry))
    else $error("return from interrupt wrong");
  ret_two_cycle_a: assert property (s_ret_issue |=> s_ret_done)
    else $error("return not two cycles");
  single_cycle_a: assert property (exec && !is_ret |=> !busy)
    else $error("plain instruction stalled");
endmodule // mise_exec

// [test/mise_prog_mem.sv]
// Program memory model: a short straight-line program of bit tests.
// Assumes the bench holds idx steady before it issues the word.
`timescale 1ns/1ns
module mise_prog_mem (
  input wire logic [2:0] idx,
  output logic [13:0] word
);
  // File 0x20 bit 3 is set first; slots after a taken skip hold loads
  // that must never reach the accumulator
  always_comb begin
    case (idx)
      3'h0: word = {mise_pkg::OPC_BIT_SET, 3'h3, 7'h20};
      3'h1: word = {mise_pkg::OPC_SKIP_ONE, 3'h3, 7'h20};
      3'h2: word = {mise_pkg::OPC_LOAD_LIT, 2'h0, 8'hEE};
      3'h3: word = {mise_pkg::OPC_SKIP_ZERO, 3'h3, 7'h20};
      3'h4: word = {mise_pkg::OPC_LOAD_LIT, 2'h0, 8'h3C};
      3'h5: word = {mise_pkg::OPC_SKIP_ZERO, 3'h2, 7'h20};
      3'h6: word = {mise_pkg::OPC_LOAD_LIT, 2'h0, 8'h77};
      default: word = 14'h0000;
    endcase
  end
endmodule // mise_prog_mem

// [test/test_mcu_instruction_subset_exec.sv]
// Testbench for the executor: issues words over AXI4-Lite, reads back.
// Assumes the package, carrier and design are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_mcu_instruction_subset_exec;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic global_irq_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic [12:0] pc;
  logic [12:0] exp_pc = 13'h0000;
  logic [2:0] pidx = 3'h0;
  logic [13:0] pword;
  int error_cnt = 0;
  int checks_done = 0;
  mise_exec mise_exec_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pc, .global_irq_enable);
  mise_prog_mem mise_prog_mem_inst (.idx(pidx), .word(pword));
  // 125 MHz clock
  initial begin
    forever #4 aclk = ~aclk;
  end
  // Write: both channels offered together, held until taken; bready and
  // rready stay high so back-to-back calls never toggle them in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rv, e)
  endtask
  // Every issued word, discarded ones too, advances the counter by one
  task automatic exec(input logic [13:0] w);
    wr(mise_pkg::OFF_INSTR, {18'h0, w});
    exp_pc++;
  endtask
  task automatic t_lit;
    exec({mise_pkg::OPC_LOAD_LIT, 2'h0, 8'h8F});
    exec({mise_pkg::OPC_ADD_LIT, 1'b0, 8'h71});
    rdchk(mise_pkg::OFF_ACC, 32'h00);
    rdchk(mise_pkg::OFF_STATUS, 32'h07);
    exec({mise_pkg::OPC_LOAD_LIT, 2'h0, 8'h55});
    rdchk(mise_pkg::OFF_STATUS, 32'h07);
    exec({mise_pkg::OPC_AND_LIT, 8'h0F});
    rdchk(mise_pkg::OFF_ACC, 32'h05);
    rdchk(mise_pkg::OFF_STATUS, 32'h03);
  endtask
  // Top file address 0x7F, both destinations
  task automatic t_file;
    wr(mise_pkg::OFF_FADDR, 32'h7F);
    wr(mise_pkg::OFF_FDATA, 32'h0A);
    exec({mise_pkg::OPC_ADD_FILE, 1'b1, 7'h7F});
    rdchk(mise_pkg::OFF_FDATA, 32'h0F);
    rdchk(mise_pkg::OFF_STATUS, 32'h00);
    exec({mise_pkg::OPC_ADD_FILE, 1'b0, 7'h7F});
    rdchk(mise_pkg::OFF_ACC, 32'h14);
    rdchk(mise_pkg::OFF_STATUS, 32'h02);
    exec({mise_pkg::OPC_AND_FILE, 1'b1, 7'h7F});
    rdchk(mise_pkg::OFF_FDATA, 32'h04);
    rdchk(mise_pkg::OFF_STATUS, 32'h02);
  endtask
  task automatic t_bits;
    exec({mise_pkg::OPC_BIT_SET, 3'h7, 7'h7F});
    exec({mise_pkg::OPC_BIT_CLR, 3'h2, 7'h7F});
    rdchk(mise_pkg::OFF_FDATA, 32'h80);
    rdchk(mise_pkg::OFF_STATUS, 32'h02);
    exec({mise_pkg::OPC_STORE_ACC, 7'h10});
    rdchk(mise_pkg::OFF_STATUS, 32'h02);
    exec({mise_pkg::OPC_MOVE_FILE, 1'b0, 7'h11});
    rdchk(mise_pkg::OFF_STATUS, 32'h06);
    exec({mise_pkg::OPC_MOVE_FILE, 1'b1, 7'h10});
    rdchk(mise_pkg::OFF_STATUS, 32'h02);
    wr(mise_pkg::OFF_FADDR, 32'h10);
    rdchk(mise_pkg::OFF_FDATA, 32'h14);
    rdchk(mise_pkg::OFF_ACC, 32'h00);
  endtask
  // Program from the memory model: two taken skips, one not taken
  task automatic t_skip;
    for (int i = 0; i < 8; i++) begin
      pidx <= i[2:0];
      @(posedge aclk);
      exec(pword);
    end
    rdchk(mise_pkg::OFF_ACC, 32'h3C);
    rdchk(mise_pkg::OFF_STATUS, 32'h02);
    `CHK(pc, exp_pc)
  endtask
  // Clock enable low: an offered word waits and nothing moves, then it runs
  task automatic t_hold;
    ce <= 1'b0;
    fork
      exec({mise_pkg::OPC_LOAD_LIT, 2'h0, 8'h66});
      begin
        repeat (4) @(posedge aclk);
        `CHK(pc, exp_pc)
        ce <= 1'b1;
      end
    join
    rdchk(mise_pkg::OFF_ACC, 32'h66);
    `CHK(pc, exp_pc)
  endtask
  task automatic t_ret;
    wr(mise_pkg::OFF_STACK, 32'h123);
    exec({mise_pkg::OPC_RET_LIT, 2'h0, 8'h5A});
    rdchk(mise_pkg::OFF_ACC, 32'h5A);
    rdchk(mise_pkg::OFF_STATUS, 32'h02);
    `CHK(pc, 13'h123)
    exec(mise_pkg::OPC_RET_IRQ);
    rdchk(mise_pkg::OFF_STATUS, 32'h0A);
    `CHK(global_irq_enable, 1'b1)
    `CHK(pc, 13'h123)
  endtask
  // Unmapped address on both channels
  task automatic t_bad;
    wr(8'h40, 32'h5);
    `CHK(rr, mise_pkg::RESP_SLVERR)
    rdchk(8'h40, 32'h0);
    `CHK(rr, mise_pkg::RESP_SLVERR)
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_lit();
    t_file();
    t_bits();
    t_skip();
    t_hold();
    t_ret();
    t_bad();
    print_verdict();
  end
  // Whole run is about 140 cycles; this cuts a hung handshake
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule // test_mcu_instruction_subset_exec
